// *** verilog/arfc_result_format.sv ***
// control and result registers of the 10-bit converter: justification,
// conversion clock select and positive reference select
// assumes a single-cycle register master and a converter core that
// presents a finished result as a one-cycle valid pulse
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "arfc_consts.svh"

module arfc_result_format
(
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     soft_reset_i,

	// register port
	input  wire arfc_pkg::arfc_bus_req_t  bus_i,
	output logic [7:0]                    rd_data_o,

	// converter core
	input  wire arfc_pkg::arfc_result_t   result_i,

	// control towards the converter
	output arfc_pkg::arfc_ctrl_t          ctrl_o,
	output arfc_pkg::arfc_ref_route_t     ref_route_o,
	output logic                          conv_tick_o,
	output logic                          rc_osc_sel_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------

	logic [7:0]                 ctrl2;
	logic [7:0]                 next_ctrl2;
	logic [7:0]                 res_high;
	logic [7:0]                 next_res_high;
	logic [7:0]                 res_low;
	logic [7:0]                 next_res_low;
	logic [7:0]                 next_rd_data;
	arfc_pkg::arfc_ctrl_t       next_ctrl;
	arfc_pkg::arfc_ref_route_t  next_route;
	logic [5:0]                 div_cnt;
	logic [5:0]                 next_div_cnt;
	logic [5:0]                 div_tc;
	logic                       rc_sel;
	logic                       next_tick;
	logic                       next_rc_sel;
	logic [2:0]                 last_sel;
	logic [2:0]                 next_last_sel;
	logic                       wr_ctrl;
	logic                       wr_res_high;
	logic                       wr_res_low;

	// ------------------------------------------------------------
	// register port decode
	// ------------------------------------------------------------

	// one decode feeds every register, so an offset cannot be caught
	// by one block and missed by another; an unmapped offset raises
	// no strobe and the write is simply dropped
	always_comb
	begin
		wr_ctrl     = 1'b0;
		wr_res_high = 1'b0;
		wr_res_low  = 1'b0;
		if (bus_i.wr)
		begin
			case (bus_i.addr)
				`ARFC_OFS_CTRL2:    wr_ctrl     = 1'b1;
				`ARFC_OFS_RES_HIGH: wr_res_high = 1'b1;
				`ARFC_OFS_RES_LOW:  wr_res_low  = 1'b1;
				default:            wr_ctrl     = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------

	always_comb
	begin
		next_ctrl2 = ctrl2;
		if (soft_reset_i)
		begin
			next_ctrl2 = `ARFC_CTRL2_RESET;
		end
		else if (wr_ctrl)
		begin
			// bits 3..2 do not exist and never store
			next_ctrl2 = bus_i.wdata & `ARFC_CTRL2_WMASK;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl2 <= `ARFC_CTRL2_RESET;
		end
		else
		begin
			ctrl2 <= next_ctrl2;
		end
	end

	// ------------------------------------------------------------
	// result registers
	// ------------------------------------------------------------

	// a finished conversion beats a software write in the same cycle,
	// so a result is never lost to a racing store
	always_comb
	begin
		next_res_high = res_high;
		next_res_low  = res_low;
		if (result_i.valid)
		begin
			if (ctrl2[`ARFC_BIT_JUSTIFY])
			begin
				next_res_high = {6'h00, result_i.value[9:8]};
				next_res_low  = result_i.value[7:0];
			end
			else
			begin
				next_res_high = result_i.value[9:2];
				next_res_low  = {result_i.value[1:0], 6'h00};
			end
		end
		else if (bus_i.wr)
		begin
			if (wr_res_high)
			begin
				next_res_high = bus_i.wdata;
			end
			if (wr_res_low)
			begin
				next_res_low = bus_i.wdata;
			end
		end
	end

	// the results have no defined power-on value; zero is used so a
	// read before the first conversion never returns unknown bits
	// soft reset deliberately does not touch the results
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			res_high <= `ARFC_RESULT_POR;
			res_low  <= `ARFC_RESULT_POR;
		end
		else
		begin
			res_high <= next_res_high;
			res_low  <= next_res_low;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------

	// data stand only in the cycle after the strobe, zero otherwise
	always_comb
	begin
		next_rd_data = `ARFC_READ_IDLE;
		if (bus_i.rd)
		begin
			case (bus_i.addr)
				`ARFC_OFS_CTRL2:    next_rd_data = ctrl2 & `ARFC_CTRL2_WMASK;
				`ARFC_OFS_RES_HIGH: next_rd_data = res_high;
				`ARFC_OFS_RES_LOW:  next_rd_data = res_low;
				default:            next_rd_data = `ARFC_READ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rd_data_o <= `ARFC_READ_IDLE;
		end
		else
		begin
			rd_data_o <= next_rd_data;
		end
	end

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------

	always_comb
	begin
		next_ctrl.justify = next_ctrl2[`ARFC_BIT_JUSTIFY];
		next_ctrl.clk_sel = next_ctrl2[`ARFC_BIT_CLKSEL_HI:`ARFC_BIT_CLKSEL_LO];
		next_ctrl.ref_sel = next_ctrl2[`ARFC_BIT_REFSEL_HI:`ARFC_BIT_REFSEL_LO];
		// the reserved code gets its own route line instead of being
		// blocked here; the converter side decides what it means
		case (next_ctrl.ref_sel)
			`ARFC_REF_VDD:   next_route = arfc_pkg::ARFC_ROUTE_SUPPLY;
			`ARFC_REF_RSVD:  next_route = arfc_pkg::ARFC_ROUTE_RESERVED;
			`ARFC_REF_PIN:   next_route = arfc_pkg::ARFC_ROUTE_EXTERNAL;
			`ARFC_REF_FIXED: next_route = arfc_pkg::ARFC_ROUTE_FIXED;
			default:         next_route = arfc_pkg::ARFC_ROUTE_SUPPLY;
		endcase
	end

	// outputs are registered copies of the next control value,
	// so they match the control register cycle for cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_o      <= '0;
			ref_route_o <= arfc_pkg::ARFC_ROUTE_SUPPLY;
		end
		else
		begin
			ctrl_o      <= next_ctrl;
			ref_route_o <= next_route;
		end
	end

	// ------------------------------------------------------------
	// conversion clock divider
	// ------------------------------------------------------------

	always_comb
	begin
		rc_sel = 1'b0;
		case (ctrl2[`ARFC_BIT_CLKSEL_HI:`ARFC_BIT_CLKSEL_LO])
			`ARFC_CS_DIV2:  div_tc = `ARFC_TC_DIV2;
			`ARFC_CS_DIV4:  div_tc = `ARFC_TC_DIV4;
			`ARFC_CS_DIV8:  div_tc = `ARFC_TC_DIV8;
			`ARFC_CS_DIV16: div_tc = `ARFC_TC_DIV16;
			`ARFC_CS_DIV32: div_tc = `ARFC_TC_DIV32;
			`ARFC_CS_DIV64: div_tc = `ARFC_TC_DIV64;
			`ARFC_CS_RC_A,
			`ARFC_CS_RC_B:
			begin
				// the rc oscillator runs elsewhere; the divider idles
				div_tc = `ARFC_TC_ZERO;
				rc_sel = 1'b1;
			end
			default:        div_tc = `ARFC_TC_DIV2;
		endcase
	end

	// the rc flag is taken from the stored selection, so it trails
	// ctrl_o by one cycle; the count is held at zero in rc mode so the
	// first divided period after leaving it is a full one
	// a new selection restarts the count so the first period after a
	// change is a full one, never a stretched or clipped one
	always_comb
	begin
		next_last_sel = ctrl2[`ARFC_BIT_CLKSEL_HI:`ARFC_BIT_CLKSEL_LO];
		next_rc_sel   = rc_sel;
		next_tick     = 1'b0;
		if (rc_sel || last_sel != next_last_sel)
		begin
			next_div_cnt = `ARFC_TC_ZERO;
		end
		else if (div_cnt >= div_tc)
		begin
			next_div_cnt = `ARFC_TC_ZERO;
			next_tick    = 1'b1;
		end
		else
		begin
			next_div_cnt = 6'(div_cnt + 6'h01);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_cnt      <= `ARFC_TC_ZERO;
			last_sel     <= `ARFC_CS_DIV2;
			conv_tick_o  <= 1'b0;
			rc_osc_sel_o <= 1'b0;
		end
		else
		begin
			div_cnt      <= next_div_cnt;
			last_sel     <= next_last_sel;
			conv_tick_o  <= next_tick;
			rc_osc_sel_o <= next_rc_sel;
		end
	end

endmodule

// *** verilog/arfc_consts.svh ***
// offsets, field positions, reset values and divider counts for the
// converter result format control block; included by the design only
`ifndef ARFC_CONSTS_SVH
`define ARFC_CONSTS_SVH

// register offsets on the plain register port
`define ARFC_OFS_CTRL2      2'h0
`define ARFC_OFS_RES_HIGH   2'h1
`define ARFC_OFS_RES_LOW    2'h2

// second control register layout
`define ARFC_BIT_JUSTIFY    7
`define ARFC_BIT_CLKSEL_HI  6
`define ARFC_BIT_CLKSEL_LO  4
`define ARFC_BIT_REFSEL_HI  1
`define ARFC_BIT_REFSEL_LO  0
`define ARFC_CTRL2_RESET    8'h00
`define ARFC_CTRL2_WMASK    8'hF3

// result registers after power-on and read data when idle
`define ARFC_RESULT_POR     8'h00
`define ARFC_READ_IDLE      8'h00

// conversion clock select codes
`define ARFC_CS_DIV2        3'h0
`define ARFC_CS_DIV8        3'h1
`define ARFC_CS_DIV32       3'h2
`define ARFC_CS_RC_A        3'h3
`define ARFC_CS_DIV4        3'h4
`define ARFC_CS_DIV16       3'h5
`define ARFC_CS_DIV64       3'h6
`define ARFC_CS_RC_B        3'h7

// divider terminal counts, ratio minus one
`define ARFC_TC_DIV2        6'h01
`define ARFC_TC_DIV4        6'h03
`define ARFC_TC_DIV8        6'h07
`define ARFC_TC_DIV16       6'h0F
`define ARFC_TC_DIV32       6'h1F
`define ARFC_TC_DIV64       6'h3F
`define ARFC_TC_ZERO        6'h00

// positive reference select codes
`define ARFC_REF_VDD        2'h0
`define ARFC_REF_RSVD       2'h1
`define ARFC_REF_PIN        2'h2
`define ARFC_REF_FIXED      2'h3

`endif

// *** verilog/arfc_pkg.sv ***
// types shared by the converter result format control block
// assumes arfc_consts.svh carries all numeric constants except the route codes defined here
package arfc_pkg;

	// one register port request, valid for one clock
	typedef struct packed
	{
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} arfc_bus_req_t;

	// decoded second control register fields
	typedef struct packed
	{
		logic       justify;
		logic [2:0] clk_sel;
		logic [1:0] ref_sel;
	} arfc_ctrl_t;

	// finished conversion from the converter core
	typedef struct packed
	{
		logic       valid;
		logic [9:0] value;
	} arfc_result_t;

	// positive reference routing, one-hot
	typedef enum logic [3:0]
	{
		ARFC_ROUTE_SUPPLY   = 4'b0001,
		ARFC_ROUTE_RESERVED = 4'b0010,
		ARFC_ROUTE_EXTERNAL = 4'b0100,
		ARFC_ROUTE_FIXED    = 4'b1000
	} arfc_ref_route_t;

endpackage

// *** tb/arfc_result_format_chk.sv ***
// assertions for the converter result format control block
// assumes one clock and the active-low asynchronous reset
`timescale 1ns/100ps
module arfc_result_format_chk
(
	// clock and reset
	input wire logic                      clk_i,
	input wire logic                      rst_n_i,
	input wire logic                      soft_reset_i,
	// register port and converter
	input wire arfc_pkg::arfc_bus_req_t   bus_i,
	input wire logic [7:0]                rd_data_o,
	input wire arfc_pkg::arfc_result_t    result_i,
	// control outputs
	input wire arfc_pkg::arfc_ctrl_t      ctrl_o,
	input wire arfc_pkg::arfc_ref_route_t ref_route_o,
	input wire logic                      conv_tick_o,
	input wire logic                      rc_osc_sel_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ----
	// properties
	// ----
	a_route_onehot: assert property (ref_route_o == (4'h1 << ctrl_o.ref_sel))
		else $error("route mismatch");
	// the flag follows the stored selection one cycle after ctrl_o
	a_rc_flag: assert property (rc_osc_sel_o == ($past(ctrl_o.clk_sel[1:0]) == 2'h3))
		else $error("rc flag mismatch");
	// two settling cycles allowed after entering rc mode
	a_rc_no_tick: assert property (rc_osc_sel_o && $past(rc_osc_sel_o, 2) |-> !conv_tick_o)
		else $error("tick in rc mode");
	a_tick_gap: assert property (conv_tick_o |=> !conv_tick_o)
		else $error("ticks back to back");
	a_read_idle: assert property (!bus_i.rd |=> rd_data_o == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property (bus_i.rd && bus_i.addr == 2'h3 |=> rd_data_o == 8'h00)
		else $error("unmapped read");
	a_ctrl_write: assert property (bus_i.wr && bus_i.addr == 2'h0 && !soft_reset_i |=>
		{ctrl_o[5:2], 2'h0, ctrl_o[1:0]} == ($past(bus_i.wdata) & 8'hF3))
		else $error("control write");
	a_soft_clear: assert property (soft_reset_i |=> ctrl_o == 6'h00)
		else $error("soft reset");
	a_ctrl_hold: assert property (!(bus_i.wr && bus_i.addr == 2'h0) && !soft_reset_i |=> $stable(ctrl_o))
		else $error("control changed");
	cover property (result_i.valid && ctrl_o.justify);
	cover property (soft_reset_i && bus_i.wr);
	cover property (conv_tick_o && ctrl_o.clk_sel == 3'h6);
endmodule

bind arfc_result_format arfc_result_format_chk u_chk
(
	.clk_i, .rst_n_i, .soft_reset_i, .bus_i, .rd_data_o, .result_i,
	.ctrl_o, .ref_route_o, .conv_tick_o, .rc_osc_sel_o
);

// *** tb/tb_arfc_result_format.sv ***
// testbench for the converter result format control block
// assumes control at offset 0, result high 1, result low 2
`timescale 1ns/100ps
module tb_arfc_result_format;
	logic                      clk_i;
	logic                      rst_n_i;
	logic                      soft_reset_i;
	arfc_pkg::arfc_bus_req_t   bus_i;
	logic [7:0]                rd_data_o;
	arfc_pkg::arfc_result_t    result_i;
	arfc_pkg::arfc_ctrl_t      ctrl_o;
	arfc_pkg::arfc_ref_route_t ref_route_o;
	logic                      conv_tick_o;
	logic                      rc_osc_sel_o;
	int                        bad_count;
	int                        checked;

	arfc_result_format uut
	(
		.clk_i, .rst_n_i, .soft_reset_i, .bus_i, .rd_data_o, .result_i,
		.ctrl_o, .ref_route_o, .conv_tick_o, .rc_osc_sel_o
	);

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ----
	// bus, result load and compare tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		checked++;
		if (got !== e)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, e);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_i <= {a, d, 2'b10};
		@(posedge clk_i);
		bus_i <= '0;
	endtask

	task automatic rc(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk_i);
		bus_i <= {a, 8'h00, 2'b01};
		@(posedge clk_i);
		bus_i <= '0;
		#1 chk(rd_data_o, e);
	endtask

	task automatic ld(input logic [9:0] r);
		@(posedge clk_i);
		result_i <= {1'b1, r};
		@(posedge clk_i);
		result_i <= '0;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_ctrl();
		rc(2'h0, 8'h00);
		wr(2'h0, 8'hFF);
		rc(2'h0, 8'hF3);
		wr(2'h3, 8'h00);
		rc(2'h3, 8'h00);
		rc(2'h0, 8'hF3);
	endtask

	task automatic t_format();
		logic [9:0] r = 10'h2A5;
		for (int j = 0; j < 2; j++)
		begin
			wr(2'h0, {j[0], 7'h00});
			ld(r);
			rc(2'h1, j[0] ? {6'h00, r[9:8]} : r[9:2]);
			rc(2'h2, j[0] ? r[7:0] : {r[1:0], 6'h00});
		end
	endtask

	// soft reset lands together with a control write and must win
	task automatic t_soft();
		wr(2'h1, 8'h5A);
		wr(2'h2, 8'hC3);
		@(posedge clk_i);
		soft_reset_i <= 1'b1;
		bus_i <= {2'h0, 8'hFF, 2'b10};
		@(posedge clk_i);
		soft_reset_i <= 1'b0;
		bus_i <= '0;
		rc(2'h0, 8'h00);
		rc(2'h1, 8'h5A);
		rc(2'h2, 8'hC3);
	endtask

	task automatic t_select();
		int n;
		byte unsigned want [8] = '{32, 8, 2, 0, 16, 4, 1, 0};
		for (int c = 0; c < 8; c++)
		begin
			wr(2'h0, {1'b0, c[2:0], 2'h0, c[1:0]});
			#1 chk(8'(ref_route_o), 8'h01 << c[1:0]);
			// settle past the slowest restart, then count one 64-cycle span;
			// the rc flag trails the stored selection by one cycle
			repeat (70) @(posedge clk_i);
			#1 chk(8'(rc_osc_sel_o), 8'(c[1:0] == 2'h3));
			n = 0;
			repeat (64)
			begin
				@(posedge clk_i);
				#1 n += conv_tick_o;
			end
			chk(8'(n), want[c]);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge clk_i);
		bad_count++;
		report_and_stop();
	end

	initial
	begin
		rst_n_i = 1'b0;
		soft_reset_i = 1'b0;
		bus_i = '0;
		result_i = '0;
		bad_count = 0;
		checked = 0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_ctrl();
		t_format();
		t_soft();
		t_select();
		report_and_stop();
	end
endmodule
